// File: hw/tcdma_top.sv
// Two-channel DMA engine with plain-port channel registers and bus master.
// Assumes a bus slave that answers each cycle with bus_done.
//
// What this block does
// - Each channel has 20-bit source, destination pointers, 16-bit count, control.
// - Count holds transfer number; with terminate-on-count channel stops after it.
// - Registers may be written any time; next transfer uses new values.
// - Serial-assigned channel ignores its pin and takes serial requests.
// - Serial transmitter paces destination-synchronized channel.
// - Serial receiver paces source-synchronized channel.
// - Control selects synchronization mode and byte or word size.
// - Control interrupt enable, with terminate-on-count set, raises interrupt after final counted transfer.
// - Terminate-on-count stops at count; otherwise channel keeps running.
// - Source and destination pointers each increment, decrement or hold.
// - Each pointer chooses memory or I/O space.
// - Fixed priority winner, or alternation at equal priority.
// - DMA beats CPU except during locked or odd-word gaps.
// - External bus hold beats DMA; DMA waits for release.
// - Maskable interrupts do not stop DMA; NMI halts it.
// - Each transfer is fetch then deposit, at least eight clocks.
// - Request source is pin, timer 2, serial port or software.
`timescale 1ns/1ps
module tcdma_top
    import tcdma_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Register write strobes, one bit per channel.
    input  wire logic [1:0]  src_wr,
    input  wire logic [1:0]  dst_wr,
    input  wire logic [1:0]  cnt_wr,
    input  wire logic [1:0]  ctl_wr,
    input  wire logic [19:0] src_wdata,
    input  wire logic [19:0] dst_wdata,
    input  wire logic [15:0] cnt_wdata,
    input  wire logic [15:0] ctl_wdata,
    input  wire logic [1:0]  sw_req,
    // Request sources.
    input  wire logic [1:0]  ext_dma_request_pins,
    input  wire logic        timer2_req,
    input  wire logic        serial_tx_ready,
    input  wire logic        serial_rx_ready,
    input  wire logic        serial_dma_sel_ch0,
    input  wire logic        serial_dma_sel_ch1,
    // Arbitration inputs.
    input  wire logic        cpu_lock_gap,
    input  wire logic        cpu_odd_word_gap,
    input  wire logic        hold_req,
    input  wire logic        nmi_req,
    // Bus master port.
    output logic             bus_req,
    output logic             bus_write,
    output logic             bus_io,
    output logic             bus_word,
    output logic [19:0]      bus_addr,
    output logic [15:0]      bus_wdata,
    input  wire logic [15:0] bus_rdata,
    input  wire logic        bus_done,
    // Readback and status.
    output logic [19:0]      src_ptr_ch0,
    output logic [19:0]      src_ptr_ch1,
    output logic [19:0]      dst_ptr_ch0,
    output logic [19:0]      dst_ptr_ch1,
    output logic [15:0]      transfer_count_reg_ch0,
    output logic [15:0]      transfer_count_reg_ch1,
    output logic [15:0]      ctl_ch0,
    output logic [15:0]      ctl_ch1,
    output logic [1:0]       dma_irq,
    output logic             dma_busy
);
    logic [19:0]  src_r [2], src_nxt [2], dst_r [2], dst_nxt [2];
    logic [15:0]  cnt_r [2], cnt_nxt [2], ctl_r [2], ctl_nxt [2];
    logic [1:0]   irq_r, irq_nxt, swp_r, swp_nxt;
    tcdma_state_e st_r, st_nxt;
    logic         ch_r, ch_nxt, last_r, last_nxt;
    logic [3:0]   tmr_r, tmr_nxt;
    logic [15:0]  wd_r, wd_nxt;
    logic [19:0]  ad_r, ad_nxt;
    logic         bw_r, bw_nxt, bio_r, bio_nxt, bwd_r, bwd_nxt;
    logic [1:0]   pin_s, req, sel_ser;
    logic         pick, grant;
    tcdma_fifo_if fif ();

    ////////////////////////////////////////////////////////////////////////
    // Pins from outside the clock domain pass the three-stage filter.
    for (genvar g = 0; g < 2; g++) begin : g_pin
        tcdma_sync u_sync (
            .clk_sys (clk_sys),
            .rst_n   (rst_n),
            .d       (ext_dma_request_pins[g]),
            .q       (pin_s[g])
        );
    end

    tcdma_fifo u_fifo (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .f       (fif)
    );

    ////////////////////////////////////////////////////////////////////////
    // Per-channel request selection and pacing.
    assign sel_ser = {serial_dma_sel_ch1, serial_dma_sel_ch0};
    always_comb begin
        logic [1:0] rs;
        logic       r;
        rs = 2'b00;
        r  = 1'b0;
        for (int c = 0; c < 2; c++) begin
            rs = ctl_r[c][TCDMA_CTL_REQSEL +: 2];
            case (rs)
                TCDMA_REQ_PIN:  r = pin_s[c];
                TCDMA_REQ_TMR2: r = timer2_req;
                TCDMA_REQ_SER:  r = 1'b0;
                TCDMA_REQ_SW:   r = swp_r[c];
                default:        r = 1'b0;
            endcase
            if (sel_ser[c] || rs == TCDMA_REQ_SER) begin
                // Transmitter paces destination sync, receiver paces source sync.
                case (ctl_r[c][TCDMA_CTL_SYNC_LO +: 2])
                    TCDMA_SYNC_DST: r = serial_tx_ready;
                    TCDMA_SYNC_SRC: r = serial_rx_ready;
                    default:        r = 1'b1;
                endcase
            end
            // Unsynchronized channels run whenever enabled.
            if (ctl_r[c][TCDMA_CTL_SYNC_LO +: 2] == TCDMA_SYNC_NONE && !sel_ser[c]) begin
                r = 1'b1;
            end
            req[c] = r && ctl_r[c][TCDMA_CTL_ENABLE];
        end
    end

    // Priority: a high-priority channel wins; equal priority alternates.
    always_comb begin
        logic p0, p1;
        p0 = ctl_r[0][TCDMA_CTL_PRIO];
        p1 = ctl_r[1][TCDMA_CTL_PRIO];
        if (req[0] && req[1]) begin
            pick = (p0 == p1) ? ~ch_r : (p1 && !p0);
        end else begin
            pick = req[1] && !req[0];
        end
        // Hold and NMI block new cycles; CPU gaps keep the bus for the CPU.
        grant = (req != 2'b00) && !hold_req && !nmi_req
                && !cpu_lock_gap && !cpu_odd_word_gap;
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencer, register update and pointer stepping.
    always_comb begin
        logic [19:0] step;
        logic        c;
        src_nxt  = src_r;
        dst_nxt  = dst_r;
        cnt_nxt  = cnt_r;
        ctl_nxt  = ctl_r;
        irq_nxt  = irq_r;
        swp_nxt  = swp_r | sw_req;
        st_nxt   = st_r;
        ch_nxt   = ch_r;
        last_nxt = last_r;
        tmr_nxt  = (tmr_r != 4'h0) ? 4'(tmr_r - 1'b1) : 4'h0;
        wd_nxt   = wd_r;
        ad_nxt   = ad_r;
        bw_nxt   = bw_r;
        bio_nxt  = bio_r;
        bwd_nxt  = bwd_r;
        fif.wr_valid = 1'b0;
        fif.wr_data  = bus_rdata;
        fif.rd_ready = 1'b0;
        c    = ch_r;
        step = ctl_r[c][TCDMA_CTL_WORD] ? 20'h0_0002 : 20'h0_0001;
        case (st_r)
            TCDMA_IDLE: begin
                if (grant && fif.wr_ready) begin
                    // The source pointer is sampled here, so fresh writes apply at once.
                    ch_nxt  = pick;
                    ad_nxt  = src_r[pick];
                    bio_nxt = ctl_r[pick][TCDMA_CTL_SIO];
                    bwd_nxt = ctl_r[pick][TCDMA_CTL_WORD];
                    bw_nxt  = 1'b0;
                    tmr_nxt = TCDMA_HALF_CYC;
                    st_nxt  = TCDMA_FETCH;
                    if (ctl_r[pick][TCDMA_CTL_REQSEL +: 2] == TCDMA_REQ_SW) begin
                        swp_nxt[pick] = sw_req[pick];
                    end
                end
            end
            TCDMA_FETCH: begin
                if (bus_done) begin
                    fif.wr_valid = 1'b1;
                    st_nxt = TCDMA_FWAIT;
                    case (ctl_r[c][TCDMA_CTL_SSTEP +: 2])
                        TCDMA_STEP_INC: src_nxt[c] = 20'(src_r[c] + step);
                        TCDMA_STEP_DEC: src_nxt[c] = 20'(src_r[c] - step);
                        default:        src_nxt[c] = src_r[c];
                    endcase
                end
            end
            TCDMA_FWAIT: begin
                // Second half of the transfer starts after the fetch minimum.
                if (tmr_r == 4'h0 && fif.rd_valid) begin
                    fif.rd_ready = 1'b1;
                    wd_nxt  = fif.rd_data;
                    ad_nxt  = dst_r[c];
                    bio_nxt = ctl_r[c][TCDMA_CTL_DIO];
                    bw_nxt  = 1'b1;
                    tmr_nxt = TCDMA_HALF_CYC;
                    st_nxt  = TCDMA_DEPOSIT;
                end
            end
            TCDMA_DEPOSIT: begin
                if (bus_done) begin
                    st_nxt = TCDMA_DWAIT;
                    case (ctl_r[c][TCDMA_CTL_DSTEP +: 2])
                        TCDMA_STEP_INC: dst_nxt[c] = 20'(dst_r[c] + step);
                        TCDMA_STEP_DEC: dst_nxt[c] = 20'(dst_r[c] - step);
                        default:        dst_nxt[c] = dst_r[c];
                    endcase
                    cnt_nxt[c] = 16'(cnt_r[c] - 1'b1);
                    last_nxt   = (cnt_r[c] == 16'h0001);
                end
            end
            TCDMA_DWAIT: begin
                if (tmr_r == 4'h0) begin
                    st_nxt   = TCDMA_IDLE;
                    last_nxt = 1'b0;
                    if (last_r && ctl_r[c][TCDMA_CTL_TC]) begin
                        ctl_nxt[c][TCDMA_CTL_ENABLE] = 1'b0;
                        if (ctl_r[c][TCDMA_CTL_INTEN]) begin
                            irq_nxt[c] = 1'b1;
                        end
                    end
                end
            end
            default: st_nxt = TCDMA_IDLE;
        endcase
        // Software writes land last and win over the engine.
        for (int k = 0; k < 2; k++) begin
            if (src_wr[k]) src_nxt[k] = src_wdata;
            if (dst_wr[k]) dst_nxt[k] = dst_wdata;
            if (cnt_wr[k]) cnt_nxt[k] = cnt_wdata;
            if (ctl_wr[k]) ctl_nxt[k] = ctl_wdata;
            // A control write clears the interrupt, unless it is set now.
            if (ctl_wr[k] && !(irq_nxt[k] && !irq_r[k])) irq_nxt[k] = 1'b0;
        end
    end

    // Register bank and sequencer flops.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < 2; k++) begin
                src_r[k] <= TCDMA_ADDR_RST;
                dst_r[k] <= TCDMA_ADDR_RST;
                cnt_r[k] <= TCDMA_CNT_RST;
                ctl_r[k] <= TCDMA_CTL_RST;
            end
            irq_r  <= 2'h0;
            swp_r  <= 2'h0;
            st_r   <= TCDMA_IDLE;
            ch_r   <= 1'b1;
            last_r <= 1'b0;
            tmr_r  <= 4'h0;
            wd_r   <= 16'h0000;
            ad_r   <= TCDMA_ADDR_RST;
            bw_r   <= 1'b0;
            bio_r  <= 1'b0;
            bwd_r  <= 1'b0;
        end else begin
            src_r  <= src_nxt;
            dst_r  <= dst_nxt;
            cnt_r  <= cnt_nxt;
            ctl_r  <= ctl_nxt;
            irq_r  <= irq_nxt;
            swp_r  <= swp_nxt;
            st_r   <= st_nxt;
            ch_r   <= ch_nxt;
            last_r <= last_nxt;
            tmr_r  <= tmr_nxt;
            wd_r   <= wd_nxt;
            ad_r   <= ad_nxt;
            bw_r   <= bw_nxt;
            bio_r  <= bio_nxt;
            bwd_r  <= bwd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs. A bus cycle already started is finished even under hold.
    assign bus_req   = (st_r == TCDMA_FETCH) || (st_r == TCDMA_DEPOSIT);
    assign bus_write = bw_r;
    assign bus_io    = bio_r;
    assign bus_word  = bwd_r;
    assign bus_addr  = ad_r;
    assign bus_wdata = wd_r;
    assign src_ptr_ch0 = src_r[0];
    assign src_ptr_ch1 = src_r[1];
    assign dst_ptr_ch0 = dst_r[0];
    assign dst_ptr_ch1 = dst_r[1];
    assign transfer_count_reg_ch0 = cnt_r[0];
    assign transfer_count_reg_ch1 = cnt_r[1];
    assign ctl_ch0  = ctl_r[0];
    assign ctl_ch1  = ctl_r[1];
    assign dma_irq  = irq_r;
    assign dma_busy = (st_r != TCDMA_IDLE);
endmodule

// File: hw/tcdma_pkg.sv
// Constants and types for the two-channel DMA controller.
// Assumes a single 250 MHz system clock and plain-port configuration.
package tcdma_pkg;
    localparam int        TCDMA_ADDR_W      = 20;
    localparam int        TCDMA_CNT_W       = 16;
    localparam int        TCDMA_DATA_W      = 16;
    localparam int        TCDMA_FIFO_DEPTH  = 16;
    localparam int        TCDMA_FIFO_AW     = 4;
    // Control register field positions.
    localparam int        TCDMA_CTL_SYNC_LO = 0;   // Two bits: 00 none, 01 source, 10 destination.
    localparam int        TCDMA_CTL_WORD    = 2;
    localparam int        TCDMA_CTL_INTEN   = 3;
    localparam int        TCDMA_CTL_TC      = 4;
    localparam int        TCDMA_CTL_PRIO    = 5;
    localparam int        TCDMA_CTL_SSTEP   = 6;   // Two bits: 00 hold, 01 increment, 10 decrement.
    localparam int        TCDMA_CTL_SIO     = 8;
    localparam int        TCDMA_CTL_DSTEP   = 9;   // Two bits, same coding as the source step.
    localparam int        TCDMA_CTL_DIO     = 11;
    localparam int        TCDMA_CTL_REQSEL  = 12;  // Two bits: 00 pin, 01 timer 2, 10 serial, 11 software.
    localparam int        TCDMA_CTL_ENABLE  = 14;
    localparam logic [1:0] TCDMA_SYNC_NONE  = 2'h0;
    localparam logic [1:0] TCDMA_SYNC_SRC   = 2'h1;
    localparam logic [1:0] TCDMA_SYNC_DST   = 2'h2;
    localparam logic [1:0] TCDMA_STEP_INC   = 2'h1;
    localparam logic [1:0] TCDMA_STEP_DEC   = 2'h2;
    localparam logic [1:0] TCDMA_REQ_PIN    = 2'h0;
    localparam logic [1:0] TCDMA_REQ_TMR2   = 2'h1;
    localparam logic [1:0] TCDMA_REQ_SER    = 2'h2;
    localparam logic [1:0] TCDMA_REQ_SW     = 2'h3;
    localparam logic [15:0] TCDMA_CTL_RST   = 16'h0000;
    localparam logic [19:0] TCDMA_ADDR_RST  = 20'h0_0000;
    localparam logic [15:0] TCDMA_CNT_RST   = 16'h0000;
    // Timer load per half; each half then spans at least five clocks, ten per transfer.
    localparam logic [3:0] TCDMA_HALF_CYC   = 4'h4;
    typedef enum logic [2:0] {TCDMA_IDLE, TCDMA_FETCH, TCDMA_FWAIT, TCDMA_DEPOSIT, TCDMA_DWAIT} tcdma_state_e;
endpackage

// File: hw/tcdma_fifo_if.sv
// Interface carrying fetched data between the engine and its staging FIFO.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface tcdma_fifo_if;
    logic [15:0] wr_data;
    logic        wr_valid;
    logic        wr_ready;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        rd_ready;
    modport fifo   (input wr_data, wr_valid, rd_ready, output wr_ready, rd_data, rd_valid);
    modport engine (output wr_data, wr_valid, rd_ready, input wr_ready, rd_data, rd_valid);
endinterface

// File: hw/tcdma_fifo.sv
// Staging FIFO between fetch and deposit cycles, registered read data.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module tcdma_fifo
    import tcdma_pkg::*;
#(
    parameter int WIDTH = TCDMA_DATA_W,
    parameter int DEPTH = TCDMA_FIFO_DEPTH,
    parameter int AW    = TCDMA_FIFO_AW
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    tcdma_fifo_if.fifo f
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic [WIDTH-1:0] q_r, q_nxt;
    logic             qv_r, qv_nxt;
    logic             push, pop_mem;

    ////////////////////////////////////////////////////////////////////////
    // Output register refills whenever it is empty or being drained.
    always_comb begin
        push    = f.wr_valid && f.wr_ready;
        pop_mem = (cnt_r != '0) && (!qv_r || f.rd_ready);
        wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
        rp_nxt  = pop_mem ? AW'(rp_r + 1'b1) : rp_r;
        cnt_nxt = (AW+1)'(cnt_r + (push ? 1'b1 : 1'b0) - (pop_mem ? 1'b1 : 1'b0));
        q_nxt   = pop_mem ? mem[rp_r] : q_r;
        qv_nxt  = pop_mem ? 1'b1 : (f.rd_ready ? 1'b0 : qv_r);
    end

    assign f.wr_ready = (cnt_r != (AW+1)'(DEPTH));
    assign f.rd_valid = qv_r;
    assign f.rd_data  = q_r;

    // Storage array is not reset, to keep it a plain memory.
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wp_r] <= f.wr_data;
        end
    end

    // Pointer and output registers.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
            q_r   <= '0;
            qv_r  <= 1'b0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
            q_r   <= q_nxt;
            qv_r  <= qv_nxt;
        end
    end
endmodule

// File: hw/tcdma_sync.sv
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/1ps
module tcdma_sync (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    logic s1_r, s2_r, s3_r, q_r, q_nxt;

    // The value only moves once the second and third stages agree.
    always_comb begin
        q_nxt = (s2_r == s3_r) ? s3_r : q_r;
    end
    assign q = q_r;

    // Synchroniser chain and filtered output.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            q_r  <= 1'b0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r  <= q_nxt;
        end
    end
endmodule

// File: dv/tcdma_chk.sv
// Checker for the DMA engine's top-level ports.
// Assumes one clock domain; bound into every tcdma_top instance.
`timescale 1ns/1ps
module tcdma_chk
    import tcdma_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic [1:0]  ctl_wr,
    input wire logic        cpu_lock_gap,
    input wire logic        cpu_odd_word_gap,
    input wire logic        hold_req,
    input wire logic        nmi_req,
    input wire logic        bus_req,
    input wire logic        bus_write,
    input wire logic [19:0] bus_addr,
    input wire logic        bus_done,
    input wire logic [15:0] ctl_ch0,
    input wire logic [15:0] ctl_ch1,
    input wire logic [1:0]  dma_irq,
    input wire logic        dma_busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // Blockers are sampled only while idle, since an in-flight cycle must finish.
    property p_hold; !dma_busy && hold_req |=> !bus_req; endproperty
    a_hold: assert property (p_hold) else $error("hold ignored");
    property p_nmi; !dma_busy && nmi_req |=> !bus_req; endproperty
    a_nmi: assert property (p_nmi) else $error("nmi ignored");
    property p_gap; !dma_busy && (cpu_lock_gap || cpu_odd_word_gap) |=> !bus_req; endproperty
    a_gap: assert property (p_gap) else $error("gap ignored");
    // Each transfer opens with a fetch and lasts eight clocks or more.
    property p_first; $rose(dma_busy) |-> bus_req && !bus_write; endproperty
    a_first: assert property (p_first) else $error("no fetch first");
    property p_min; $rose(dma_busy) |-> dma_busy [*8]; endproperty
    a_min: assert property (p_min) else $error("short transfer");
    property p_stable; bus_req && !bus_done |=> bus_req && $stable(bus_addr) && $stable(bus_write); endproperty
    a_stable: assert property (p_stable) else $error("bus cycle moved");
    // The interrupt needs its enable and stays until a control write.
    property p_irq_src; $rose(dma_irq[0]) |-> $past(ctl_ch0[TCDMA_CTL_INTEN]); endproperty
    a_irq_src: assert property (p_irq_src) else $error("irq while disabled");
    property p_irq_keep; dma_irq[0] && !ctl_wr[0] |=> dma_irq[0]; endproperty
    a_irq_keep: assert property (p_irq_keep) else $error("irq dropped");
    property p_off; !dma_busy && !ctl_ch0[TCDMA_CTL_ENABLE] && !ctl_ch1[TCDMA_CTL_ENABLE] && ctl_wr == 2'b00 |=> !bus_req; endproperty
    a_off: assert property (p_off) else $error("disabled channel ran");
    c_irq: cover property ($rose(dma_irq[0]));
    c_dep: cover property (bus_req && bus_write && bus_done);
    c_hold: cover property (hold_req && dma_busy);
endmodule
bind tcdma_top tcdma_chk u_chk (.clk_sys, .rst_n, .ctl_wr, .cpu_lock_gap, .cpu_odd_word_gap, .hold_req,
    .nmi_req, .bus_req, .bus_write, .bus_addr, .bus_done, .ctl_ch0, .ctl_ch1, .dma_irq, .dma_busy);

// File: dv/tcdma_mem_model.sv
// Memory and I/O slave answering the engine's bus cycles.
// Assumes bus_req holds until bus_done.
`timescale 1ns/1ps
module tcdma_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        bus_req,
    input  wire logic [19:0] bus_addr,
    input  wire logic [3:0]  wait_cyc,
    output logic             bus_done,
    output logic [15:0]      bus_rdata
);
    logic [3:0] cnt_r;
    // Read data is a fixed function of the address; it toggles when not answering.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
            bus_done <= 1'b0;
            bus_rdata <= 16'h0000;
        end else if (bus_req && !bus_done && cnt_r == wait_cyc) begin
            bus_done <= 1'b1;
            bus_rdata <= bus_addr[15:0] ^ 16'h5a5a;
            cnt_r <= 4'h0;
        end else begin
            bus_done <= 1'b0;
            bus_rdata <= ~bus_rdata; // Stale data must not look valid.
            cnt_r <= (bus_req && !bus_done) ? cnt_r + 4'h1 : 4'h0;
        end
    end
endmodule

// File: dv/test_two_channel_dma_controller.sv
// Self-checking bench for the two-channel DMA engine.
// Assumes the memory model as bus slave.
`timescale 1ns/1ps
module test_two_channel_dma_controller
    import tcdma_pkg::*;
;
    logic        clk_sys = 0, rst_n = 0, timer2_req = 0, serial_tx_ready = 0, serial_rx_ready = 0;
    logic        serial_dma_sel_ch0 = 0, serial_dma_sel_ch1 = 0, cpu_lock_gap = 0, cpu_odd_word_gap = 0;
    logic        hold_req = 0, nmi_req = 0, bus_done, bus_req, bus_write, bus_io, bus_word, dma_busy, wio;
    logic [1:0]  src_wr = 0, dst_wr = 0, cnt_wr = 0, ctl_wr = 0, sw_req = 0, ext_dma_request_pins = 0, dma_irq;
    logic [19:0] src_wdata = 0, dst_wdata = 0, bus_addr, waddr, sp[2], dp[2];
    logic [15:0] cnt_wdata = 0, ctl_wdata = 0, bus_rdata, bus_wdata, wdata, cn[2], ct[2];
    logic [3:0]  wait_cyc = 0, fq[$];
    int          err_total = 0, comparisons = 0, cyc = 0;
    tcdma_top uut (.clk_sys, .rst_n, .src_wr, .dst_wr, .cnt_wr, .ctl_wr, .src_wdata, .dst_wdata, .cnt_wdata,
        .ctl_wdata, .sw_req, .ext_dma_request_pins, .timer2_req, .serial_tx_ready, .serial_rx_ready,
        .serial_dma_sel_ch0, .serial_dma_sel_ch1, .cpu_lock_gap, .cpu_odd_word_gap, .hold_req, .nmi_req,
        .bus_req, .bus_write, .bus_io, .bus_word, .bus_addr, .bus_wdata, .bus_rdata, .bus_done,
        .src_ptr_ch0(sp[0]), .src_ptr_ch1(sp[1]), .dst_ptr_ch0(dp[0]), .dst_ptr_ch1(dp[1]),
        .transfer_count_reg_ch0(cn[0]), .transfer_count_reg_ch1(cn[1]), .ctl_ch0(ct[0]), .ctl_ch1(ct[1]),
        .dma_irq, .dma_busy);
    tcdma_mem_model u_mem (.clk_sys, .rst_n, .bus_req, .bus_addr, .wait_cyc, .bus_done, .bus_rdata);
    always #2 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    // Logs fetches and the last deposit; the ceiling cuts a hang short.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (bus_req && bus_done && !bus_write) fq.push_back(bus_addr[19:16]);
        if (bus_req && bus_done && bus_write) {waddr, wdata, wio} <= {bus_addr, bus_wdata, bus_io};
        if (cyc == 40000) begin
            err_total++;
            summarize();
        end
    end
    task summarize();
        if (err_total == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(string nm, logic [19:0] exp, logic [19:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Writes one channel's four registers in one strobe cycle; returns one clock after the write lands, without reading back.
    task prog(int ch, logic [19:0] s, logic [19:0] d, logic [15:0] n, logic [15:0] c);
        @(posedge clk_sys);
        {src_wr, dst_wr, cnt_wr, ctl_wr} <= {4{2'(1 << ch)}};
        {src_wdata, dst_wdata, cnt_wdata, ctl_wdata} <= {s, d, n, c};
        @(posedge clk_sys);
        {src_wr, dst_wr, cnt_wr, ctl_wr} <= 8'h00;
        @(posedge clk_sys);
    endtask
    task wait_idle(int ch);
        int i;
        for (i = 0; i < 900 && (ct[ch][TCDMA_CTL_ENABLE] !== 1'b0 || dma_busy !== 1'b0); i++) @(posedge clk_sys);
        chk("wait", 20'h0, 20'(i / 900));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Word copy of three units with a slow slave, then irq clear.
    task t_count();
        wait_cyc <= 4'h3;
        prog(0, 20'h1_0100, 20'h3_0200, 16'h0003, 16'h425c);
        wait_idle(0);
        chk("src", 20'h1_0106, sp[0]);
        chk("dst", 20'h3_0206, dp[0]);
        chk("count", 20'h0, 20'(cn[0]));
        chk("ctl", 20'h25c, 20'(ct[0]));
        chk("irq", 20'h1, 20'(dma_irq[0]));
        chk("waddr", 20'h3_0204, waddr);
        chk("wdata", 20'h5b5e, 20'(wdata));
        wait_cyc <= 4'h0;
        prog(0, 20'h1_0100, 20'h3_0200, 16'h0000, 16'h0000);
        chk("irq clear", 20'h0, 20'(dma_irq[0]));
    endtask
    // Byte I/O copy with decrementing source and constant destination.
    task t_byte();
        prog(1, 20'h2_0010, 20'h2_0400, 16'h0002, 16'h4990);
        wait_idle(1);
        chk("src", 20'h2_000e, sp[1]);
        chk("dst", 20'h2_0400, dp[1]);
        chk("byte", 20'h55, 20'(wdata[7:0]));
        chk("io", 20'h1, 20'(wio));
        chk("no irq", 20'h0, 20'(dma_irq[1]));
    endtask
    // Each blocker holds a ready transfer back until released.
    task t_block();
        for (int b = 0; b < 4; b++) begin
            {cpu_lock_gap, cpu_odd_word_gap, hold_req, nmi_req} <= 4'(1 << b);
            prog(0, 20'h1_0000, 20'h3_0000, 16'h0001, 16'h4054);
            repeat (30) @(posedge clk_sys);
            chk("blocked", 20'h1, 20'(cn[0]));
            {cpu_lock_gap, cpu_odd_word_gap, hold_req, nmi_req} <= 4'h0;
            wait_idle(0);
            chk("released", 20'h0, 20'(cn[0]));
        end
    endtask
    // Paced channel waits for its selected source only; the pin is ignored under serial.
    task t_paced(logic [1:0] sel, logic [1:0] sync);
        serial_dma_sel_ch0 <= (sel == TCDMA_REQ_SER);
        ext_dma_request_pins <= {1'b0, sel == TCDMA_REQ_SER};
        {serial_tx_ready, serial_rx_ready} <= {sync == TCDMA_SYNC_SRC, sync == TCDMA_SYNC_DST};
        prog(0, 20'h1_0000, 20'h3_0000, 16'h0001, 16'h4010 | 16'(sel) << 12 | 16'(sync));
        repeat (40) @(posedge clk_sys);
        chk("paced idle", 20'h1, 20'(cn[0]));
        case (sel)
            TCDMA_REQ_PIN: ext_dma_request_pins <= 2'b01;
            TCDMA_REQ_TMR2: timer2_req <= 1'b1;
            TCDMA_REQ_SW: sw_req <= 2'b01;
            default: {serial_tx_ready, serial_rx_ready} <= {sync == TCDMA_SYNC_DST, sync == TCDMA_SYNC_SRC};
        endcase
        @(posedge clk_sys);
        sw_req <= 2'b00;
        wait_idle(0);
        chk("paced done", 20'h0, 20'(cn[0]));
        {ext_dma_request_pins, timer2_req, serial_tx_ready, serial_rx_ready, serial_dma_sel_ch0} <= 6'h00;
    endtask
    // Both channels armed under hold, then released together.
    task t_prio(logic [15:0] c1, logic [15:0] e0, logic [15:0] e1);
        hold_req <= 1'b1;
        prog(0, 20'h1_0000, 20'h3_0000, 16'h0002, 16'h4054);
        prog(1, 20'h2_0000, 20'h3_1000, 16'h0002, c1);
        fq.delete();
        hold_req <= 1'b0;
        wait_idle(0);
        wait_idle(1);
        chk("fetches", 20'h4, 20'(fq.size()));
        chk("order", 20'({e0[7:0], e1[7:0]}), 20'({fq[0], fq[1], fq[2], fq[3]}));
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        t_count();
        t_byte();
        t_block();
        t_paced(TCDMA_REQ_PIN, TCDMA_SYNC_SRC);
        t_paced(TCDMA_REQ_TMR2, TCDMA_SYNC_SRC);
        t_paced(TCDMA_REQ_SW, TCDMA_SYNC_DST);
        t_paced(TCDMA_REQ_SER, TCDMA_SYNC_DST);
        t_paced(TCDMA_REQ_SER, TCDMA_SYNC_SRC);
        t_prio(16'h4074, 16'h0022, 16'h0011);
        t_prio(16'h4054, 16'h0021, 16'h0021);
        summarize();
    end
endmodule
